// ### hmc_measure_ctrl.v
`include "hmc_defines.vh"

// Harvester measurement scheduling and control registers
module hmc_measure_ctrl #(
	parameter CYC_PER_MS = `HMC_MS_CYCLES
) (
	input  wire        core_clk_i,
	input  wire        srst_i,
	// Register port from the serial front end
	input  wire        reg_wr_i,
	input  wire [7:0]  reg_addr_i,
	input  wire [7:0]  reg_wdata_i,
	output reg  [7:0]  reg_rdata_o,
	// Neighbouring configuration and analog status
	input  wire        measurement_inhibit_i,
	input  wire        periodic_open_circuit_i,
	input  wire        periodic_thermal_i,
	input  wire        sleep_i,
	input  wire [15:0] harvest_counter_i,
	input  wire        thermal_hot_i,
	input  wire        wake_cmp_i,
	input  wire        enable_pin_n_i,
	input  wire        boost_logic_on_i,
	// Analog controls
	output reg  [9:0]  reg_point_permille_o,
	output reg  [9:0]  peak_current_ma_o,
	output reg         oc_measuring_o,
	output reg         oc_sample_o,
	output reg         thermal_check_o,
	output reg         measure_busy_o,
	output wire        wake_o,
	output wire        device_enable_o,
	output wire        boost_enable_o
);

	localparam ST_IDLE = 2'd0;
	localparam ST_OC   = 2'd1;
	localparam ST_THM  = 2'd2;

	// ==========================================================
	// Lookup functions
	function [9:0] tmeas_ms;
		input [1:0] code;
		begin
			case (code)
				2'd0:    tmeas_ms = `HMC_TMEAS0_MS;
				2'd1:    tmeas_ms = `HMC_TMEAS1_MS;
				2'd2:    tmeas_ms = `HMC_TMEAS2_MS;
				default: tmeas_ms = `HMC_TMEAS3_MS;
			endcase
		end
	endfunction

	// Strong harvest settles faster; weak harvest waits longer
	function [10:0] settle_ms;
		input [9:0]  tm;
		input        adaptive;
		input [15:0] cnt;
		begin
			if (!adaptive)
				settle_ms = {1'b0, tm};
			else if (cnt >= 16'h4000)
				settle_ms = {3'b000, tm[9:2]};
			else if (cnt >= 16'h1000)
				settle_ms = {2'b00, tm[9:1]};
			else if (cnt >= 16'h0100)
				settle_ms = {1'b0, tm};
			else
				settle_ms = {tm, 1'b0};
		end
	endfunction

	function [9:0] peak_ma;
		input [2:0] code;
		begin
			case (code)
				3'd0:    peak_ma = 10'd90;
				3'd1:    peak_ma = 10'd120;
				3'd2:    peak_ma = 10'd145;
				3'd3:    peak_ma = 10'd180;
				3'd4:    peak_ma = 10'd285;
				3'd5:    peak_ma = 10'd355;
				3'd6:    peak_ma = 10'd470;
				default: peak_ma = 10'd715;
			endcase
		end
	endfunction

	// ==========================================================
	// Registers
	reg  [4:0]  frac_q;
	reg  [1:0]  tmeas_q;
	reg         adp_settle_q;
	reg         adp_period_q;
	reg  [1:0]  tper_q;
	reg  [2:0]  peak_q;
	reg         thermal_enable_q;
	reg         wake_override_q;
	reg         software_disable_q;
	reg         boost_disable_q;

	reg         oc_req_q;
	reg         thm_req_q;
	reg         first_q;
	reg  [1:0]  state_q;
	reg  [10:0] settle_cnt_q;
	reg  [31:0] presc_q;
	reg         ms_tick_q;
	reg         restart_q;
	reg  [10:0] store_cnt_q;
	reg         store_wait_q;
	reg         stored_valid_q;
	reg  [15:0] stored_cnt_q;
	reg         thermal_trip_q;

	wire        wr_meas;
	wire        frc_oc;
	wire        frc_thm;
	wire        period_exp;
	wire        auto_on;
	wire        ratio_out;
	wire [9:0]  tm_ms;
	wire [16:0] cnt_x2;
	wire [16:0] stored_x2;

	assign tm_ms     = tmeas_ms(tmeas_q);
	assign wr_meas   = reg_wr_i && reg_addr_i == `HMC_OFS_MEAS;
	// Zero writes to the force bits do nothing
	assign frc_oc    = wr_meas && reg_wdata_i[`HMC_BIT_FRC_OC] && !measurement_inhibit_i;
	assign frc_thm   = wr_meas && reg_wdata_i[`HMC_BIT_FRC_THM] && thermal_enable_q;
	assign auto_on   = tper_q != `HMC_TPER_OFF;
	assign cnt_x2    = {harvest_counter_i, 1'b0};
	assign stored_x2 = {stored_cnt_q, 1'b0};
	// Ratio below one half or above two
	assign ratio_out = cnt_x2 < {1'b0, stored_cnt_q} || {1'b0, harvest_counter_i} > stored_x2;

	// ==========================================================
	// Register writes
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			frac_q             <= `HMC_RST_MPPT;
			tmeas_q            <= `HMC_RST_TMEAS;
			adp_settle_q       <= `HMC_RST_ADP_SETTLE;
			adp_period_q       <= `HMC_RST_ADP_PERIOD;
			tper_q             <= `HMC_RST_TPER;
			peak_q             <= `HMC_RST_PEAK;
			thermal_enable_q   <= 1'b0;
			wake_override_q    <= 1'b0;
			software_disable_q <= 1'b0;
			boost_disable_q    <= 1'b0;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`HMC_OFS_MPPT: begin
					frac_q <= reg_wdata_i[4:0];
				end
				`HMC_OFS_MEAS: begin
					tmeas_q      <= reg_wdata_i[`HMC_BIT_TMEAS_LO +: 2];
					adp_settle_q <= reg_wdata_i[`HMC_BIT_ADP_SETTLE];
					adp_period_q <= reg_wdata_i[`HMC_BIT_ADP_PERIOD];
					tper_q       <= reg_wdata_i[`HMC_BIT_TPER_LO +: 2];
				end
				`HMC_OFS_DEVCTL: begin
					peak_q             <= reg_wdata_i[`HMC_BIT_PEAK_LO +: 3];
					thermal_enable_q   <= reg_wdata_i[`HMC_BIT_THM_EN];
					wake_override_q    <= reg_wdata_i[`HMC_BIT_WAKE_OVR];
					software_disable_q <= reg_wdata_i[`HMC_BIT_SW_DIS];
					boost_disable_q    <= reg_wdata_i[`HMC_BIT_BOOST_DIS];
				end
				default: begin
					frac_q <= frac_q;
				end
			endcase
		end
	end

	// ==========================================================
	// Read mux; force bits and unmapped offsets read zero
	always @* begin
		case (reg_addr_i)
			`HMC_OFS_MPPT:   reg_rdata_o = {3'b000, frac_q};
			`HMC_OFS_MEAS:   reg_rdata_o = {2'b00, tmeas_q, adp_settle_q, adp_period_q, tper_q};
			`HMC_OFS_DEVCTL: reg_rdata_o = {1'b0, peak_q, thermal_enable_q, wake_override_q,
			                                software_disable_q, boost_disable_q};
			default:         reg_rdata_o = 8'h00;
		endcase
	end

	// ==========================================================
	// Millisecond prescaler; CYC_PER_MS shortens it in simulation
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			presc_q   <= 32'h00000000;
			ms_tick_q <= 1'b0;
		end else if (presc_q >= CYC_PER_MS - 1) begin
			presc_q   <= 32'h00000000;
			ms_tick_q <= 1'b1;
		end else begin
			presc_q   <= presc_q + 32'h00000001;
			ms_tick_q <= 1'b0;
		end
	end

	hmc_period_timer u_period (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.ms_tick_i  (ms_tick_q),
		.restart_i  (restart_q),
		.tmeas_ms_i (tm_ms),
		.tper_i     (tper_q),
		.expire_o   (period_exp)
	);

	// ==========================================================
	// Pending requests; a new request wins over the start that clears it
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			oc_req_q  <= 1'b0;
			thm_req_q <= 1'b0;
			first_q   <= 1'b1;
		end else begin
			first_q <= 1'b0;
			if (state_q == ST_IDLE && oc_req_q)
				oc_req_q <= 1'b0;
			else if (state_q == ST_IDLE && thm_req_q)
				thm_req_q <= 1'b0;
			if (frc_oc
			    || (first_q && periodic_open_circuit_i && !measurement_inhibit_i)
			    || (period_exp && auto_on && periodic_open_circuit_i
			        && !measurement_inhibit_i)
			    || (adp_period_q && auto_on && stored_valid_q && !sleep_i && ratio_out
			        && !measurement_inhibit_i && state_q == ST_IDLE
			        && !oc_req_q && !oc_sample_o)) // one force per event, not per cycle
				oc_req_q <= 1'b1;
			if (frc_thm
			    || (period_exp && auto_on && periodic_thermal_i && thermal_enable_q))
				thm_req_q <= 1'b1;
		end
	end

	// ==========================================================
	// Measurement sequencer: open-circuit first, then thermal
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			state_q         <= ST_IDLE;
			settle_cnt_q    <= 11'h000;
			oc_measuring_o  <= 1'b0;
			oc_sample_o     <= 1'b0;
			thermal_check_o <= 1'b0;
			restart_q       <= 1'b0;
			thermal_trip_q  <= 1'b0;
		end else begin
			oc_sample_o     <= 1'b0;
			thermal_check_o <= 1'b0;
			restart_q       <= 1'b0;
			if (!thermal_enable_q)
				thermal_trip_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (oc_req_q) begin
						state_q        <= ST_OC;
						oc_measuring_o <= 1'b1;
						settle_cnt_q   <= settle_ms(tm_ms, adp_settle_q, harvest_counter_i);
					end else if (thm_req_q && thermal_enable_q) begin
						state_q         <= ST_THM;
						thermal_check_o <= 1'b1;
					end
				end
				ST_OC: begin
					if (settle_cnt_q == 11'h000) begin
						oc_measuring_o <= 1'b0;
						oc_sample_o    <= 1'b1;
						restart_q      <= 1'b1;
						state_q        <= ST_IDLE;
					end else if (ms_tick_q) begin
						settle_cnt_q <= settle_cnt_q - 11'h001;
					end
				end
				ST_THM: begin
					// Comparator result is taken one cycle after the strobe
					thermal_trip_q <= thermal_hot_i && thermal_enable_q;
					restart_q      <= 1'b1;
					state_q        <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Adaptive period: store the count 2 x Tmeas after a measurement
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			store_wait_q   <= 1'b0;
			store_cnt_q    <= 11'h000;
			stored_valid_q <= 1'b0;
			stored_cnt_q   <= 16'h0000;
		end else if (!adp_period_q || !auto_on) begin
			store_wait_q   <= 1'b0;
			stored_valid_q <= 1'b0;
		end else if (oc_sample_o) begin
			store_wait_q   <= 1'b1;
			stored_valid_q <= 1'b0;
			store_cnt_q    <= {tm_ms, 1'b0};
		end else if (store_wait_q) begin
			if (store_cnt_q == 11'h000) begin
				store_wait_q   <= 1'b0;
				stored_valid_q <= 1'b1;
				stored_cnt_q   <= harvest_counter_i;
			end else if (ms_tick_q) begin
				store_cnt_q <= store_cnt_q - 11'h001;
			end
		end
	end

	// ==========================================================
	// Registered analog settings
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			reg_point_permille_o <= 10'h000;
			peak_current_ma_o    <= 10'h000;
			measure_busy_o       <= 1'b0;
		end else begin
			reg_point_permille_o <= `HMC_FRAC_BASE + `HMC_FRAC_STEP * {5'b00000, frac_q};
			peak_current_ma_o    <= peak_ma(peak_q);
			measure_busy_o       <= state_q != ST_IDLE || oc_req_q || thm_req_q;
		end
	end

	// ==========================================================
	// Overrides act at once, like the analog paths they gate
	assign wake_o          = wake_override_q || wake_cmp_i;
	assign device_enable_o = !software_disable_q && !enable_pin_n_i;
	assign boost_enable_o  = !boost_disable_q && boost_logic_on_i && !thermal_trip_q;

endmodule // hmc_measure_ctrl

// ### hmc_defines.vh
`ifndef HMC_DEFINES_VH
`define HMC_DEFINES_VH

// ==========================================================
// Register offsets
`define HMC_OFS_MPPT        8'h06
`define HMC_OFS_MEAS        8'h07
`define HMC_OFS_DEVCTL      8'h08

// ==========================================================
// Reset values
`define HMC_RST_MPPT        5'h19
`define HMC_RST_TMEAS       2'h0
`define HMC_RST_ADP_SETTLE  1'b1
`define HMC_RST_ADP_PERIOD  1'b1
`define HMC_RST_TPER        2'h2
`define HMC_RST_PEAK        3'h3

// ==========================================================
// Field positions
`define HMC_BIT_FRC_OC      7
`define HMC_BIT_FRC_THM     6
`define HMC_BIT_TMEAS_LO    4
`define HMC_BIT_ADP_SETTLE  3
`define HMC_BIT_ADP_PERIOD  2
`define HMC_BIT_TPER_LO     0
`define HMC_BIT_PEAK_LO     4
`define HMC_BIT_THM_EN      3
`define HMC_BIT_WAKE_OVR    2
`define HMC_BIT_SW_DIS      1
`define HMC_BIT_BOOST_DIS   0
`define HMC_TPER_OFF        2'h3

// ==========================================================
// Fraction scale in tenths of a percent
`define HMC_FRAC_BASE       10'd425
`define HMC_FRAC_STEP       10'd15

// ==========================================================
// Timing
`define HMC_CLK_HZ          100000000
`define HMC_MS_CYCLES       (`HMC_CLK_HZ / 1000)
`define HMC_TMEAS0_MS       10'd50
`define HMC_TMEAS1_MS       10'd100
`define HMC_TMEAS2_MS       10'd250
`define HMC_TMEAS3_MS       10'd500
`define HMC_PER_SHIFT_BASE  6

`endif

// ### hmc_period_timer.v
`include "hmc_defines.vh"

// Automatic period timer, counted in milliseconds
module hmc_period_timer (
	input  wire        core_clk_i,
	input  wire        srst_i,
	input  wire        ms_tick_i,
	input  wire        restart_i,
	input  wire [9:0]  tmeas_ms_i,
	input  wire [1:0]  tper_i,
	output reg         expire_o
);

	reg  [17:0] count_q;
	wire [17:0] limit;

	// ==========================================================
	// Period length: Tmeas shifted by 6, 7 or 8
	assign limit = {8'h00, tmeas_ms_i} << (`HMC_PER_SHIFT_BASE + tper_i);

	// Live settings are used, so a reprogrammed Tmeas takes effect at once
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			count_q  <= 18'h00000;
			expire_o <= 1'b0;
		end else begin
			expire_o <= 1'b0;
			if (restart_i || tper_i == `HMC_TPER_OFF) begin
				count_q <= 18'h00000;
			end else if (ms_tick_i) begin
				if (count_q + 18'h00001 >= limit) begin
					count_q  <= 18'h00000;
					expire_o <= 1'b1;
				end else begin
					count_q <= count_q + 18'h00001;
				end
			end
		end
	end

endmodule // hmc_period_timer

// ### hmc_measure_ctrl_assertions.sv
// ==========================================================
// Port-level checks on the measurement controller
module hmc_measure_ctrl_assertions #(
	parameter CYC_PER_MS = 2
) (
	input wire       core_clk_i,
	input wire       srst_i,
	input wire       reg_wr_i,
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire [7:0] reg_rdata_o,
	input wire       measurement_inhibit_i,
	input wire       wake_cmp_i,
	input wire       enable_pin_n_i,
	input wire       boost_logic_on_i,
	input wire [9:0] reg_point_permille_o,
	input wire [9:0] peak_current_ma_o,
	input wire       oc_measuring_o,
	input wire       oc_sample_o,
	input wire       thermal_check_o,
	input wire       measure_busy_o,
	input wire       wake_o,
	input wire       device_enable_o,
	input wire       boost_enable_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (srst_i);

	// Steps of a forced request and of the single-cycle pulses
	sequence s_force;
		reg_wr_i && reg_addr_i == 8'h07 && reg_wdata_i[7] && !measurement_inhibit_i;
	endsequence
	sequence s_th_pulse;
		thermal_check_o ##1 !thermal_check_o;
	endsequence
	sequence s_oc_end;
		$past(oc_measuring_o) ##1 !oc_sample_o;
	endsequence

	force_req_a: assert property (s_force |-> ##[1:2] measure_busy_o)
		else $error("forced measure not taken");
	th_pulse_a: assert property (thermal_check_o |-> s_th_pulse)
		else $error("thermal pulse too long");
	settle_end_a: assert property (oc_sample_o |-> s_oc_end)
		else $error("sample without settling");
	wake_high_a: assert property (wake_cmp_i |-> wake_o)
		else $error("wake not following comparator");
	dev_off_a: assert property (enable_pin_n_i |-> !device_enable_o)
		else $error("device enabled with pin high");
	boost_off_a: assert property (!boost_logic_on_i |-> !boost_enable_o)
		else $error("boost on against logic");
	frac_scale_a: assert property (reg_point_permille_o == 10'h000 || (reg_point_permille_o >= 425 &&
		reg_point_permille_o <= 890 && (reg_point_permille_o - 425) % 15 == 0))
		else $error("regulation point off scale");
	peak_code_a: assert property (peak_current_ma_o inside {0, 90, 120, 145, 180, 285, 355, 470, 715})
		else $error("peak current not a table value");
	force_bits_a: assert property (reg_addr_i == 8'h07 |-> reg_rdata_o[7:6] == 2'h0)
		else $error("force bits read back");
endmodule // hmc_measure_ctrl_assertions

// ### hmc_host_model.sv
// ==========================================================
// Host side of the register port
module hmc_host_model (
	input  wire        core_clk_i,
	input  wire [7:0]  reg_rdata_i,
	output logic       reg_wr_o,
	output logic [7:0] reg_addr_o,
	output logic [7:0] reg_wdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle port from time zero
	initial begin
		reg_wr_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
	end
	// One strobe per write; the result register is never touched here
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk_i);
		reg_wr_o = 1'b1;
		reg_addr_o = a;
		reg_wdata_o = d;
		@(negedge core_clk_i);
		reg_wr_o = 1'b0;
		reg_wdata_o = ~d;
	endtask
	// Read data is combinational, taken at the rising edge
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk_i);
		reg_addr_o = a;
		@(posedge core_clk_i);
		d = reg_rdata_i;
	endtask
endmodule // hmc_host_model

// ### harvester_measure_control_bench.sv
// ==========================================================
// Bench for the measurement controller
module harvester_measure_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int C = 2;
	logic clk = 1'b0, srst = 1'b1, inh = 1'b0, poc = 1'b0, pth = 1'b0, slp = 1'b0, hot = 1'b0;
	logic wcmp = 1'b0, enn = 1'b0, blog = 1'b1;
	logic [15:0] hcnt = 16'h4000;
	wire wr, ocm, ocs, thc, busy, wake, den, ben;
	wire [7:0] ad, wd, rd;
	wire [9:0] rp, pk;
	int n_fail = 0, cmp_count = 0, seed = 97, oc_n = 0, th_n = 0, cyc = 0;
	int i, k, n, o, t;
	int m [6:8];
	int mk [6:8] = '{8'h1f, 8'h3f, 8'h7f};
	int pkt [8] = '{90, 120, 145, 180, 285, 355, 470, 715};
	int tm [4] = '{50, 100, 250, 500};

	hmc_measure_ctrl #(.CYC_PER_MS(C)) dut_u (.core_clk_i(clk), .srst_i(srst), .reg_wr_i(wr),
		.reg_addr_i(ad), .reg_wdata_i(wd), .reg_rdata_o(rd), .measurement_inhibit_i(inh),
		.periodic_open_circuit_i(poc), .periodic_thermal_i(pth), .sleep_i(slp), .harvest_counter_i(hcnt),
		.thermal_hot_i(hot), .wake_cmp_i(wcmp), .enable_pin_n_i(enn), .boost_logic_on_i(blog),
		.reg_point_permille_o(rp), .peak_current_ma_o(pk), .oc_measuring_o(ocm), .oc_sample_o(ocs),
		.thermal_check_o(thc), .measure_busy_o(busy), .wake_o(wake), .device_enable_o(den),
		.boost_enable_o(ben));
	hmc_host_model host_u (.core_clk_i(clk), .reg_rdata_i(rd), .reg_wr_o(wr), .reg_addr_o(ad),
		.reg_wdata_o(wd));

	always #5 clk = ~clk;
	// Pulse counters and watchdog; a hang counts as a mismatch
	always @(negedge clk) begin
		cyc++;
		if (ocs === 1'b1) oc_n++;
		if (thc === 1'b1) th_n++;
		if (cyc == 100000) begin
			n_fail++;
			results();
		end
	end

	// ==========================================================
	// Shared tasks
	task chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// Write and keep the readback model in step
	task w(input logic [7:0] a, input logic [7:0] d);
		host_u.wr(a, d);
		if (a inside {[6:8]}) m[a] = d & mk[a];
	endtask
	task rc(input logic [7:0] a);
		logic [7:0] d;
		host_u.rd(a, d);
		chk(d, (a inside {[6:8]}) ? m[a] : 0);
	endtask
	// Wait for settling to begin, then time it
	task ocl(output int wt, output int len);
		wt = 0;
		len = 0;
		while (ocm !== 1'b1 && wt < 20000) begin
			@(negedge clk);
			wt++;
		end
		while (ocm === 1'b1 && len < 5000) begin
			@(negedge clk);
			len++;
		end
	endtask
	task results;
		$display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (3) @(negedge clk);
		srst = 1'b0;
		m[6] = 8'h19;
		m[7] = 8'h0e;
		m[8] = 8'h30;
		repeat (2) @(negedge clk);
		for (i = 5; i < 11; i++) rc(i);
		chk(rp, 425 + 15 * m[6]);
		chk(pk, 180);
		chk(busy, 0);
		$display("test reset done");
		w(7, 8'h03);
		// Fraction and peak-current codes, fraction code 31 and every peak code included
		for (i = 0; i < 8; i++) begin
			t = (i == 0) ? 31 : ($random(seed) & 31);
			w(6, t);
			@(negedge clk); // Registered output lags the write by one cycle
			chk(rp, 425 + 15 * t);
			rc(6);
			w(8, i << 4);
			@(negedge clk);
			chk(pk, pkt[i]);
			rc(8);
		end
		$display("test codes done");
		// Inhibited request, then each measurement time and one adaptive case
		inh = 1'b1;
		o = oc_n;
		w(7, 8'h83);
		repeat (20) @(negedge clk);
		chk(oc_n - o, 0);
		chk(busy, 0);
		inh = 1'b0;
		for (t = 0; t < 5; t++) begin
			w(7, (t < 4) ? (8'h83 | (t << 4)) : 8'h9b);
			ocl(k, n);
			i = (t == 4) ? 25 : tm[t];
			chk(n >= (i - 1) * C && n <= (i + 1) * C + 2, 1);
			rc(7);
		end
		o = oc_n;
		w(7, 8'h03);
		repeat (20) @(negedge clk);
		chk(oc_n - o, 0);
		$display("test forced measure done");
		// Thermal requests with the enable off, then hot and cool checks
		hot = 1'b1;
		w(8, 8'h00);
		o = th_n;
		w(7, 8'h43);
		repeat (5) @(negedge clk);
		chk(th_n - o, 0);
		chk(ben, 1);
		w(8, 8'h08);
		w(7, 8'h43);
		repeat (5) @(negedge clk);
		chk(th_n - o, 1);
		chk(ben, 0);
		hot = 1'b0;
		w(7, 8'h43);
		repeat (5) @(negedge clk);
		chk(ben, 1);
		$display("test thermal done");
		// Override bits against random pin and comparator levels
		for (i = 0; i < 8; i++) begin
			w(8, i);
			{wcmp, enn, blog} = $random(seed);
			@(negedge clk);
			chk(wake, i[2] | wcmp);
			chk(den, !i[1] & !enn);
			chk(ben, !i[0] & blog);
		end
		$display("test overrides done");
		// Automatic period, then period off
		enn = 1'b0;
		poc = 1'b1;
		pth = 1'b1;
		w(8, 8'h08);
		o = th_n;
		w(7, 8'h00);
		ocl(k, n);
		ocl(k, n);
		chk(k + n >= 64 * 50 * C - 2 * C && k + n <= 65 * 50 * C + 4 * C, 1);
		chk(th_n > o, 1);
		w(7, 8'h03);
		o = oc_n;
		t = th_n;
		repeat (14000) @(negedge clk);
		chk(oc_n - o, 0);
		chk(th_n - t, 0);
		$display("test period done");
		// Mid-run reset with the periodic bit set, then adaptive period forcing
		poc = 1'b1;
		pth = 1'b0;
		srst = 1'b1;
		repeat (3) @(negedge clk);
		srst = 1'b0;
		m[6] = 8'h19;
		m[7] = 8'h0e;
		m[8] = 8'h30;
		ocl(k, n);
		chk(k <= 3, 1);
		chk(n >= 12 * C && n <= 13 * C, 1);
		@(negedge clk);
		o = oc_n;
		// Count moves inside the 2 x Tmeas wait, so the late value is stored
		hcnt = 16'h1000;
		for (i = 6; i < 9; i++) rc(i);
		repeat (150) @(negedge clk);
		chk(oc_n - o, 0);
		repeat (100) @(negedge clk);
		slp = 1'b1;
		hcnt = 16'h2400;
		repeat (20) @(negedge clk);
		chk(oc_n - o, 0);
		slp = 1'b0;
		ocl(k, n);
		chk(k <= 3, 1);
		chk(n >= 25 * C && n <= 26 * C, 1);
		@(negedge clk);
		o = oc_n;
		repeat (100) @(negedge clk);
		chk(oc_n - o, 0);
		$display("test adaptive done");
		results();
	end
endmodule // harvester_measure_control_bench

bind hmc_measure_ctrl hmc_measure_ctrl_assertions #(.CYC_PER_MS(CYC_PER_MS)) chk_u (
	.core_clk_i            (core_clk_i),
	.srst_i                (srst_i),
	.reg_wr_i              (reg_wr_i),
	.reg_addr_i            (reg_addr_i),
	.reg_wdata_i           (reg_wdata_i),
	.reg_rdata_o           (reg_rdata_o),
	.measurement_inhibit_i (measurement_inhibit_i),
	.wake_cmp_i            (wake_cmp_i),
	.enable_pin_n_i        (enable_pin_n_i),
	.boost_logic_on_i      (boost_logic_on_i),
	.reg_point_permille_o  (reg_point_permille_o),
	.peak_current_ma_o     (peak_current_ma_o),
	.oc_measuring_o        (oc_measuring_o),
	.oc_sample_o           (oc_sample_o),
	.thermal_check_o       (thermal_check_o),
	.measure_busy_o        (measure_busy_o),
	.wake_o                (wake_o),
	.device_enable_o       (device_enable_o),
	.boost_enable_o        (boost_enable_o)
);
